// File: pkg/pmem_map_pkg.sv
// Constants for the program memory map, identity words and protection block.
// Assumes a single core clock; shared by the design and its bench.
package pmem_map_pkg;
	localparam int PC_WIDTH        = 15;
	localparam int WORD_WIDTH      = 14;
	localparam int BYTE_WIDTH      = 8;
	localparam int PAGE_WORDS_SMALL = 4096;
	localparam int PAGE_WORDS_LARGE = 8192;
	localparam logic [14:0] RESET_VECTOR = 15'h0000;
	localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
	localparam int STORAGE_WORDS   = 128;
	localparam int PTR_PROG_BIT    = 7;
	// Configuration-space word offsets
	localparam logic [15:0] REVISION_OFFSET = 16'h8005;
	localparam logic [15:0] PART_OFFSET     = 16'h8006;
	// APB byte addresses (four times the word offset)
	localparam logic [17:0] ADDR_REVISION   = 18'h20014;
	localparam logic [17:0] ADDR_PART       = 18'h20018;
	localparam logic [17:0] ADDR_PROTECT    = 18'h00000;
	localparam logic [17:0] ADDR_PARTITION  = 18'h00004;
	localparam logic [17:0] ADDR_CONTROL    = 18'h00008;
	localparam logic [17:0] ADDR_STATUS     = 18'h0000C;
	// Protection word fields
	localparam int FLASH_LOCK_BIT  = 0;
	localparam int EEPROM_LOCK_BIT = 1;
	localparam logic [1:0] LOCK_RESET = 2'h3;
	// Partition word fields
	localparam int BOOT_SIZE_LSB   = 0;
	localparam int BOOT_EN_BIT     = 3;
	localparam int STORAGE_EN_BIT  = 4;
	localparam logic [4:0] PARTITION_RESET = 5'h1F;
	// Control word: bulk erase strobe
	localparam int BULK_ERASE_BIT  = 0;
	// Identity word fixed bits
	localparam logic [1:0] PART_RSVD = 2'h3;
	localparam logic [1:0] REV_RSVD  = 2'h2;
	localparam int CODE_LSB = 0;
	localparam int MINOR_LSB = 0;
	localparam int MAJOR_LSB = 6;
	localparam int RSVD_LSB  = 12;
	// Arbitrary identity values
	localparam logic [11:0] PART_CODE_DEFAULT = 12'hA5C;
	localparam logic [5:0]  MAJOR_DEFAULT     = 6'h01;
	localparam logic [5:0]  MINOR_DEFAULT     = 6'h00;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_DONE  = 3'b100
	} ind_state_type;
endpackage

// File: rtl/pmem_map.sv
// Program memory map: PC wrap, vectors, indirect read of program memory,
// identity words, protection and partition configuration over APB.
// Assumes program memory answers a read in the same cycle as its address.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module pmem_map #(
	parameter int          PROG_WORDS = pmem_map_pkg::PAGE_WORDS_LARGE,
	parameter logic [11:0] PART_CODE  = pmem_map_pkg::PART_CODE_DEFAULT,
	parameter logic [5:0]  MAJOR_REV  = pmem_map_pkg::MAJOR_DEFAULT,
	parameter logic [5:0]  MINOR_REV  = pmem_map_pkg::MINOR_DEFAULT
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [17:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR,
	// Core fetch side
	input  wire logic        CORE_RESET_REQ,
	input  wire logic        CORE_IRQ_TAKE,
	input  wire logic        CORE_PC_LOAD,
	input  wire logic [14:0] CORE_PC_VALUE,
	input  wire logic        CORE_PC_STEP,
	output logic [14:0]      FETCH_ADDR,
	output logic             FETCH_EXEC_FAULT,
	// Indirect access from core
	input  wire logic        IND_REQ,
	input  wire logic        IND_WRITE,
	input  wire logic [7:0]  IND_PTR_HIGH,
	input  wire logic [7:0]  IND_PTR_LOW,
	input  wire logic [7:0]  IND_WDATA,
	output logic             IND_DONE,
	output logic [7:0]       IND_RDATA,
	output logic             IND_STALL,
	// Program memory read port
	output logic [14:0]      PMEM_ADDR,
	output logic             PMEM_RD,
	input  wire logic [13:0] PMEM_RDATA,
	// Data memory path
	output logic             DMEM_REQ,
	output logic             DMEM_WRITE,
	output logic [14:0]      DMEM_ADDR,
	output logic [7:0]       DMEM_WDATA,
	input  wire logic [7:0]  DMEM_RDATA,
	// Protection and partition state
	output logic             FLASH_PROTECTED,
	output logic             EEPROM_PROTECTED,
	output logic             BOOT_REGION_ACTIVE,
	output logic             STORAGE_AREA_ACTIVE
);
	import pmem_map_pkg::*;

	localparam logic [14:0] ADDR_MASK = 15'(PROG_WORDS - 1);
	localparam logic [14:0] STORAGE_BASE = 15'(PROG_WORDS - STORAGE_WORDS);

	logic [1:0]  lock_n;
	logic [4:0]  partition;
	logic [14:0] pc;
	logic [14:0] next_pc;
	ind_state_type state;
	logic        apb_access;
	logic        apb_wr;
	logic        bulk_erase;
	logic [13:0] part_word;
	logic [13:0] rev_word;
	logic [31:0] next_rdata;
	logic        next_err;

	assign apb_access = PSEL && PENABLE && !PREADY;
	assign apb_wr     = apb_access && PWRITE;
	assign bulk_erase = apb_wr && PADDR == ADDR_CONTROL && PWDATA[BULK_ERASE_BIT];

	assign part_word = {PART_RSVD, PART_CODE};
	assign rev_word  = {REV_RSVD, MAJOR_REV, MINOR_REV};

	// APB: one wait state, answer on second access cycle
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		unique case (PADDR)
			ADDR_PART:      next_rdata = 32'(part_word);
			ADDR_REVISION:  next_rdata = 32'(rev_word);
			ADDR_PROTECT:   next_rdata = 32'(lock_n);
			ADDR_PARTITION: next_rdata = 32'(partition);
			ADDR_CONTROL:   next_rdata = 32'h0000_0000;
			ADDR_STATUS:    next_rdata = 32'({STORAGE_AREA_ACTIVE, BOOT_REGION_ACTIVE,
						EEPROM_PROTECTED, FLASH_PROTECTED});
			default:        next_err = 1'b1;
		endcase
		if (PWRITE && (PADDR == ADDR_PART || PADDR == ADDR_REVISION || PADDR == ADDR_STATUS))
			next_err = 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= apb_access;
			PRDATA  <= (apb_access && !PWRITE) ? next_rdata : 32'h0000_0000;
			PSLVERR <= apb_access && next_err;
		end
	end

	// Lock bits: writes may only clear; bulk erase sets both
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			lock_n <= LOCK_RESET;
		end else if (bulk_erase) begin
			lock_n <= LOCK_RESET;
		end else if (apb_wr && PADDR == ADDR_PROTECT) begin
			lock_n <= lock_n & {PWDATA[EEPROM_LOCK_BIT], PWDATA[FLASH_LOCK_BIT]};
		end
	end

	// Protection takes effect the cycle after the lock bit clears
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			FLASH_PROTECTED  <= 1'b0;
			EEPROM_PROTECTED <= 1'b0;
		end else begin
			FLASH_PROTECTED  <= !lock_n[FLASH_LOCK_BIT];
			EEPROM_PROTECTED <= !lock_n[EEPROM_LOCK_BIT];
		end
	end

	// Partition word; size frozen once boot region enabled
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			partition <= PARTITION_RESET;
		end else if (bulk_erase) begin
			partition <= PARTITION_RESET;
		end else if (apb_wr && PADDR == ADDR_PARTITION) begin
			partition[STORAGE_EN_BIT] <= PWDATA[STORAGE_EN_BIT];
			partition[BOOT_EN_BIT]    <= PWDATA[BOOT_EN_BIT];
			if (partition[BOOT_EN_BIT])
				partition[2:0] <= PWDATA[2:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			BOOT_REGION_ACTIVE  <= 1'b0;
			STORAGE_AREA_ACTIVE <= 1'b0;
		end else begin
			BOOT_REGION_ACTIVE  <= !partition[BOOT_EN_BIT];
			STORAGE_AREA_ACTIVE <= !partition[STORAGE_EN_BIT];
		end
	end

	// Program counter with wrap into implemented space
	always_comb begin
		next_pc = pc;
		if (CORE_RESET_REQ)
			next_pc = RESET_VECTOR;
		else if (CORE_IRQ_TAKE)
			next_pc = IRQ_VECTOR;
		else if (CORE_PC_LOAD)
			next_pc = CORE_PC_VALUE & ADDR_MASK;
		else if (CORE_PC_STEP && !IND_STALL)
			next_pc = (pc + 15'h0001) & ADDR_MASK;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N)
			pc <= RESET_VECTOR;
		else
			pc <= next_pc;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			FETCH_ADDR       <= RESET_VECTOR;
			FETCH_EXEC_FAULT <= 1'b0;
		end else begin
			FETCH_ADDR       <= next_pc;
			FETCH_EXEC_FAULT <= !partition[STORAGE_EN_BIT]
				&& next_pc >= STORAGE_BASE;
		end
	end

	// Indirect access sequencer
	logic ind_prog;
	assign ind_prog = IND_PTR_HIGH[PTR_PROG_BIT];

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state      <= ST_IDLE;
			IND_DONE   <= 1'b0;
			IND_RDATA  <= 8'h00;
			IND_STALL  <= 1'b0;
			PMEM_ADDR  <= RESET_VECTOR;
			PMEM_RD    <= 1'b0;
			DMEM_REQ   <= 1'b0;
			DMEM_WRITE <= 1'b0;
			DMEM_ADDR  <= 15'h0000;
			DMEM_WDATA <= 8'h00;
		end else begin
			IND_DONE <= 1'b0;
			PMEM_RD  <= 1'b0;
			DMEM_REQ <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (IND_REQ && ind_prog && !IND_WRITE) begin
						PMEM_ADDR <= {IND_PTR_HIGH[6:0], IND_PTR_LOW}
							& ADDR_MASK;
						PMEM_RD   <= 1'b1;
						IND_STALL <= 1'b1;
						state     <= ST_FETCH;
					end else if (IND_REQ && ind_prog) begin
						IND_DONE <= 1'b1;
					end else if (IND_REQ) begin
						DMEM_REQ   <= 1'b1;
						DMEM_WRITE <= IND_WRITE;
						DMEM_ADDR  <= {IND_PTR_HIGH[6:0], IND_PTR_LOW};
						DMEM_WDATA <= IND_WDATA;
						state      <= ST_DONE;
					end
				end
				ST_FETCH: begin
					IND_RDATA <= PMEM_RDATA[7:0];
					IND_DONE  <= 1'b1;
					IND_STALL <= 1'b0;
					state     <= ST_IDLE;
				end
				ST_DONE: begin
					IND_RDATA <= DMEM_WRITE ? 8'h00 : DMEM_RDATA;
					IND_DONE  <= 1'b1;
					state     <= ST_IDLE;
				end
			endcase
		end
	end

	a_lock_sticky: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		$fell(lock_n[FLASH_LOCK_BIT]) ##1 !bulk_erase [*3] |-> !lock_n[FLASH_LOCK_BIT])
		else $error("flash lock returned without bulk erase");
	a_protect_follow: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		$fell(lock_n[FLASH_LOCK_BIT]) |=> FLASH_PROTECTED)
		else $error("flash protection late");
	a_eeprom_follow: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		$fell(lock_n[EEPROM_LOCK_BIT]) |=> EEPROM_PROTECTED)
		else $error("eeprom protection late");
	a_part_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_access && !PWRITE && PADDR == ADDR_PART |=> PRDATA[13:12] == PART_RSVD && PREADY)
		else $error("part word reserved bits wrong");
	a_rev_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_access && !PWRITE && PADDR == ADDR_REVISION |=> PRDATA[13:12] == REV_RSVD)
		else $error("revision reserved bits wrong");
	a_reset_vector: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		CORE_RESET_REQ |=> FETCH_ADDR == RESET_VECTOR)
		else $error("reset vector wrong");
	a_irq_vector: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!CORE_RESET_REQ && CORE_IRQ_TAKE |=> FETCH_ADDR == IRQ_VECTOR)
		else $error("interrupt vector wrong");
	a_pc_wrap: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		FETCH_ADDR <= ADDR_MASK)
		else $error("fetch address beyond memory");
	a_prog_extra: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		state == ST_IDLE && IND_REQ && ind_prog && !IND_WRITE
		|=> IND_STALL && !IND_DONE ##1 IND_DONE && IND_RDATA == $past(PMEM_RDATA[7:0]))
		else $error("program read timing or data wrong");
	a_prog_no_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		state == ST_IDLE && IND_REQ && ind_prog |=> !DMEM_REQ)
		else $error("program-space access reached data memory");
	a_data_path: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		state == ST_IDLE && IND_REQ && !ind_prog |=> DMEM_REQ && !PMEM_RD)
		else $error("data access missed data path");
	a_default_app: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		partition[BOOT_EN_BIT] && partition[STORAGE_EN_BIT]
		|=> !BOOT_REGION_ACTIVE && !STORAGE_AREA_ACTIVE)
		else $error("default partition not all application");
	a_storage_fault: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!partition[STORAGE_EN_BIT] && next_pc >= STORAGE_BASE |=> FETCH_EXEC_FAULT)
		else $error("execution in storage area not flagged");
	a_lock_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!lock_n[FLASH_LOCK_BIT] && !bulk_erase |=> !lock_n[FLASH_LOCK_BIT])
		else $error("flash lock set without bulk erase");
	a_eeprom_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!lock_n[EEPROM_LOCK_BIT] && !bulk_erase |=> !lock_n[EEPROM_LOCK_BIT])
		else $error("eeprom lock set without bulk erase");
	a_erase_restore: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		bulk_erase |=> lock_n == LOCK_RESET && partition == PARTITION_RESET)
		else $error("bulk erase did not restore defaults");
	a_flash_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_wr && PADDR == ADDR_PROTECT && !PWDATA[FLASH_LOCK_BIT] |=> ##1 FLASH_PROTECTED)
		else $error("flash protection not applied after write");
	a_eeprom_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_wr && PADDR == ADDR_PROTECT && !PWDATA[EEPROM_LOCK_BIT] |=> ##1 EEPROM_PROTECTED)
		else $error("eeprom protection not applied after write");
	a_part_code: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_access && !PWRITE && PADDR == ADDR_PART |=> PRDATA[CODE_LSB +: 12] == PART_CODE)
		else $error("part code field wrong");
	a_rev_fields: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_access && !PWRITE && PADDR == ADDR_REVISION |=> PRDATA[MAJOR_LSB +: 6] == MAJOR_REV
		&& PRDATA[MINOR_LSB +: 6] == MINOR_REV) else $error("revision fields wrong");
	a_size_frozen: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		apb_wr && PADDR == ADDR_PARTITION && !partition[BOOT_EN_BIT]
		|=> partition[2:0] == $past(partition[2:0])) else $error("boot size changed");
	a_ind_write_ignored: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		state == ST_IDLE && IND_REQ && ind_prog && IND_WRITE |=> IND_DONE && !PMEM_RD && !IND_STALL)
		else $error("program-space write not ignored");

	c_prog_read: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
		state == ST_FETCH ##1 IND_DONE);
	c_lock_set: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
		$fell(lock_n[FLASH_LOCK_BIT]));
	c_bulk_erase: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!lock_n[FLASH_LOCK_BIT] ##1 bulk_erase);
	c_wrap: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
		FETCH_ADDR == ADDR_MASK ##1 FETCH_ADDR == RESET_VECTOR);
	c_storage_fault: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
		!FETCH_EXEC_FAULT ##1 FETCH_EXEC_FAULT);
endmodule

// File: testbench/test_pmem_map.sv
// Bench for the program memory map block: APB registers, PC, indirect access.
// Assumes the default variant of 8192 words and the package identity values.
`timescale 1ns/1ns
module test_pmem_map;
	import pmem_map_pkg::*;
	logic        CLK_SYS, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [17:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic        CORE_RESET_REQ, CORE_IRQ_TAKE, CORE_PC_LOAD, CORE_PC_STEP, FETCH_EXEC_FAULT;
	logic [14:0] CORE_PC_VALUE, FETCH_ADDR, PMEM_ADDR, DMEM_ADDR, cap_pa, cap_da;
	logic        IND_REQ, IND_WRITE, IND_DONE, IND_STALL, PMEM_RD, DMEM_REQ, DMEM_WRITE, cap_we;
	logic [7:0]  IND_PTR_HIGH, IND_PTR_LOW, IND_WDATA, IND_RDATA, DMEM_WDATA, DMEM_RDATA, cap_wd;
	logic [13:0] PMEM_RDATA;
	logic        FLASH_PROTECTED, EEPROM_PROTECTED, BOOT_REGION_ACTIVE, STORAGE_AREA_ACTIVE;
	int          n_mismatch, n_checks;

	pmem_map i_dut (.CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
		.PRDATA, .PSLVERR, .CORE_RESET_REQ, .CORE_IRQ_TAKE, .CORE_PC_LOAD, .CORE_PC_VALUE,
		.CORE_PC_STEP, .FETCH_ADDR, .FETCH_EXEC_FAULT, .IND_REQ, .IND_WRITE, .IND_PTR_HIGH,
		.IND_PTR_LOW, .IND_WDATA, .IND_DONE, .IND_RDATA, .IND_STALL, .PMEM_ADDR, .PMEM_RD,
		.PMEM_RDATA, .DMEM_REQ, .DMEM_WRITE, .DMEM_ADDR, .DMEM_WDATA, .DMEM_RDATA,
		.FLASH_PROTECTED, .EEPROM_PROTECTED, .BOOT_REGION_ACTIVE, .STORAGE_AREA_ACTIVE);

	initial begin
		CLK_SYS = 1'h0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end

	task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// One APB transfer, then compare the error flag and, on reads, the data
	task acc(input logic wr, input logic [17:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic experr);
		int n;
		@(posedge CLK_SYS);
		PSEL    <= 1'h1;
		PENABLE <= 1'h0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'h1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (PREADY !== 1'h1 && n < 16);
		check("pready", 32'h1, {31'h0, PREADY});
		check("pslverr", {31'h0, experr}, {31'h0, PSLVERR});
		if (!wr) check("prdata", exp, PRDATA);
		PSEL    <= 1'h0;
		PENABLE <= 1'h0;
	endtask

	// Pulse {reset, irq, load, step} one cycle, then compare fetch address and fault
	task pc(input logic [3:0] req, input logic [14:0] v, input logic [14:0] exp,
		input logic fault);
		@(posedge CLK_SYS);
		{CORE_RESET_REQ, CORE_IRQ_TAKE, CORE_PC_LOAD, CORE_PC_STEP} <= req;
		CORE_PC_VALUE <= v;
		@(posedge CLK_SYS);
		{CORE_RESET_REQ, CORE_IRQ_TAKE, CORE_PC_LOAD, CORE_PC_STEP} <= 4'h0;
		@(posedge CLK_SYS);
		#1;
		check("fetch_addr", {17'h0, exp}, {17'h0, FETCH_ADDR});
		check("exec_fault", {31'h0, fault}, {31'h0, FETCH_EXEC_FAULT});
	endtask

	// Indirect request; latency counted from the taking edge to the done pulse
	task ind(input logic wr, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] wd,
		input logic [31:0] lat_exp, input logic prog);
		logic [31:0] lat;
		logic        pm, dm, st;
		@(posedge CLK_SYS);
		IND_REQ      <= 1'h1;
		IND_WRITE    <= wr;
		IND_PTR_HIGH <= hi;
		IND_PTR_LOW  <= lo;
		IND_WDATA    <= wd;
		@(posedge CLK_SYS);
		IND_REQ <= 1'h0;
		#1;
		{pm, dm, st} = 3'h0;
		for (lat = 1; lat < 8; lat++) begin
			if (PMEM_RD === 1'h1) {pm, cap_pa} = {1'h1, PMEM_ADDR};
			if (DMEM_REQ === 1'h1) {dm, cap_da, cap_we, cap_wd} = {1'h1, DMEM_ADDR, DMEM_WRITE, DMEM_WDATA};
			if (IND_STALL === 1'h1) st = 1'h1;
			if (IND_DONE === 1'h1) break;
			@(posedge CLK_SYS);
			#1;
		end
		check("ind_latency", lat_exp, lat);
		check("pmem_rd_seen", {31'h0, prog & ~wr}, {31'h0, pm});
		check("dmem_req_seen", {31'h0, ~prog}, {31'h0, dm});
		check("stall_seen", {31'h0, prog & ~wr}, {31'h0, st});
	endtask

	initial begin
		repeat (5000) @(posedge CLK_SYS);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		{ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{CORE_RESET_REQ, CORE_IRQ_TAKE, CORE_PC_LOAD, CORE_PC_STEP, CORE_PC_VALUE} = '0;
		{IND_REQ, IND_WRITE, IND_PTR_HIGH, IND_PTR_LOW, IND_WDATA} = '0;
		PMEM_RDATA = 14'h2ABC;
		DMEM_RDATA = 8'h5A;
		n_mismatch = 0;
		n_checks   = 0;
		repeat (6) @(posedge CLK_SYS);
		ARST_N <= 1'h1;
		#1;
		check("fetch_after_reset", 32'h0, {17'h0, FETCH_ADDR});
		acc(1'h0, ADDR_STATUS, 32'h0, 32'h0, 1'h0);
		acc(1'h0, ADDR_PARTITION, 32'h0, 32'h1F, 1'h0);
		acc(1'h0, ADDR_REVISION, 32'h0, {18'h0, REV_RSVD, MAJOR_DEFAULT, MINOR_DEFAULT}, 1'h0);
		acc(1'h0, ADDR_PART, 32'h0, {18'h0, PART_RSVD, PART_CODE_DEFAULT}, 1'h0);
		acc(1'h1, ADDR_REVISION, 32'hFFFFFFFF, 32'h0, 1'h1);
		acc(1'h1, ADDR_PART, 32'h0, 32'h0, 1'h1);
		acc(1'h0, ADDR_PART, 32'h0, {18'h0, PART_RSVD, PART_CODE_DEFAULT}, 1'h0);
		acc(1'h0, 18'h20010, 32'h0, 32'h0, 1'h1);
		// Storage area enabled: last 128 words refuse execution
		acc(1'h1, ADDR_PARTITION, 32'h0F, 32'h0, 1'h0);
		pc(4'h2, 15'h1F80, 15'h1F80, 1'h1);
		pc(4'h2, 15'h1F7F, 15'h1F7F, 1'h0);
		pc(4'h1, 15'h0, 15'h1F80, 1'h1);
		acc(1'h1, ADDR_PARTITION, 32'h07, 32'h0, 1'h0);
		acc(1'h1, ADDR_PARTITION, 32'h02, 32'h0, 1'h0);
		acc(1'h0, ADDR_PARTITION, 32'h0, 32'h07, 1'h0);
		check("boot_active", 32'h1, {31'h0, BOOT_REGION_ACTIVE});
		acc(1'h0, ADDR_STATUS, 32'h0, 32'h0C, 1'h0);
		// Lock bits clear one way only until bulk erase
		acc(1'h1, ADDR_PROTECT, 32'h1, 32'h0, 1'h0);
		@(posedge CLK_SYS);
		#1;
		check("eeprom_prot", 32'h1, {31'h0, EEPROM_PROTECTED});
		check("flash_prot", 32'h0, {31'h0, FLASH_PROTECTED});
		acc(1'h1, ADDR_PROTECT, 32'h3, 32'h0, 1'h0);
		acc(1'h0, ADDR_PROTECT, 32'h0, 32'h1, 1'h0);
		acc(1'h1, ADDR_PROTECT, 32'h0, 32'h0, 1'h0);
		acc(1'h0, ADDR_STATUS, 32'h0, 32'h0F, 1'h0);
		check("flash_prot", 32'h1, {31'h0, FLASH_PROTECTED});
		acc(1'h1, ADDR_CONTROL, 32'h1, 32'h0, 1'h0);
		acc(1'h0, ADDR_PROTECT, 32'h0, 32'h3, 1'h0);
		check("prot_cleared", 32'h0, {30'h0, FLASH_PROTECTED, EEPROM_PROTECTED});
		// Program counter wrap and vectors
		pc(4'h2, 15'h7FFF, 15'h1FFF, 1'h0);
		pc(4'h1, 15'h0, 15'h0000, 1'h0);
		pc(4'h4, 15'h0, IRQ_VECTOR, 1'h0);
		pc(4'hA, 15'h0123, RESET_VECTOR, 1'h0);
		// Indirect access in both spaces
		ind(1'h0, 8'h81, 8'h23, 8'h0, 32'h2, 1'h1);
		check("pmem_addr", 32'h0123, {17'h0, cap_pa});
		check("ind_rdata", 32'hBC, {24'h0, IND_RDATA});
		ind(1'h0, 8'hBF, 8'h23, 8'h0, 32'h2, 1'h1);
		check("pmem_addr_wrap", 32'h1F23, {17'h0, cap_pa});
		ind(1'h1, 8'h80, 8'h10, 8'h77, 32'h1, 1'h1);
		ind(1'h0, 8'h01, 8'h23, 8'h0, 32'h2, 1'h0);
		check("dmem_addr", 32'h23, {24'h0, cap_da[7:0]});
		check("dmem_rdata", 32'h5A, {24'h0, IND_RDATA});
		ind(1'h1, 8'h00, 8'h45, 8'h99, 32'h2, 1'h0);
		check("dmem_write", 32'h199, {23'h0, cap_we, cap_wd});
		tally_and_finish;
	end
endmodule
